// ### shared/shbsi_pkg.sv
package shbsi_pkg;

  // Resistor class on the protocol strap, as reported by the strap comparator
  typedef enum logic [2:0] {
    SHBSI_SPI4    = 3'h0,
    SHBSI_SPI3    = 3'h1,
    SHBSI_LINK2   = 3'h2,
    SHBSI_R82K    = 3'h3,
    SHBSI_R100K   = 3'h4,
    SHBSI_R120K   = 3'h5,
    SHBSI_R150K   = 3'h6,
    SHBSI_TIED_HI = 3'h7
  } shbsi_strap_t;

  localparam logic [6:0] ADDR_R82K    = 7'h2C;
  localparam logic [6:0] ADDR_R100K   = 7'h2B;
  localparam logic [6:0] ADDR_R120K   = 7'h2A;
  localparam logic [6:0] ADDR_R150K   = 7'h29;
  localparam logic [6:0] ADDR_TIED_HI = 7'h28;
  localparam logic [6:0] ADDR_ALERT   = 7'h0C;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_REG,
    ST_REG_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK,
    ST_RNEXT,
    ST_IGNORE
  } shbsi_state_t;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  localparam int CLK_NS     = 25;
  localparam int CLK_MHZ    = 40;
  localparam int SPIKE_NS   = 50;
  localparam int POWERUP_US = 15000;
  localparam int TIMEOUT_US = 30000;
  localparam int IDLE_US    = 150;

  localparam int FILT_CYC    = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int IDLE_CYC    = IDLE_US * CLK_MHZ;
  localparam int CNT_W       = 21;

endpackage

// ### shared/shbsi_line_if.sv
`timescale 1ns/1ps
`default_nettype none
interface shbsi_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport filt (output scl, sda, scl_rise, scl_fall, start, stop);
  modport core (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface
`default_nettype wire

// ### logic/shbsi_line_filter.sv
`timescale 1ns/1ps
`default_nettype none
module shbsi_line_filter (
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   scl_pin,
  input  wire logic   sda_pin,
  shbsi_line_if.filt  line
);
  logic [1:0] pin_in;
  logic [1:0] lvl_q;
  logic [1:0] lvl_prev_q;

  assign pin_in = {sda_pin, scl_pin};

  genvar i;
  for (i = 0; i < 2; i++) begin : g_line
    logic       s1_q;
    logic       s2_q;
    logic [1:0] cnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_q <= 1'b1;
        s2_q <= 1'b1;
      end else begin
        s1_q <= pin_in[i];
        s2_q <= s1_q;
      end
    end
    // Level must hold past the spike window before it is believed
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q    <= 2'h0;
        lvl_q[i] <= 1'b1;
      end else if (s2_q == lvl_q[i]) begin
        cnt_q <= 2'h0;
      end else if (cnt_q == 2'(shbsi_pkg::FILT_CYC - 1)) begin
        cnt_q    <= 2'h0;
        lvl_q[i] <= s2_q;
      end else begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_prev_q <= 2'h3;
    end else begin
      lvl_prev_q <= lvl_q;
    end
  end

  assign line.scl      = lvl_q[0];
  assign line.sda      = lvl_q[1];
  assign line.scl_rise = lvl_q[0] & ~lvl_prev_q[0];
  assign line.scl_fall = ~lvl_q[0] & lvl_prev_q[0];
  assign line.start    = lvl_q[0] & lvl_prev_q[0] & ~lvl_q[1] & lvl_prev_q[1];
  assign line.stop     = lvl_q[0] & lvl_prev_q[0] & lvl_q[1] & ~lvl_prev_q[1];
endmodule
`default_nettype wire

// ### logic/shbsi_slave.sv
// Contract
// (RULE1) Strap class picks 4-wire SPI, 3-wire SPI or companion link.
// (RULE2) Strap class 82k..tied-high gives bus slave address 0101_100..0101_000.
// (RULE3) Send, receive, read, write byte plus block read and write accepted.
// (RULE4) Host may stretch the clock; device never drives the clock.
// (RULE5) Start is data falling while clock is high.
// (RULE6) First byte is 7-bit address then direction, 1 meaning read.
// (RULE7) Bytes are eight bits, most significant bit first.
// (RULE8) Device acknowledges each received byte by pulling data low.
// (RULE9) Host acknowledges read bytes except the last, which it leaves high.
// (RULE10) Stop, data rising while clock high, resets slave protocol.
// (RULE11) Clock low for 30ms resets the interface when timeout enabled.
// (RULE12) Timeout is off after reset until the enable bit is set.
// (RULE13) Clock and data high over 150us resets the slave protocol.
// (RULE14) Blocks carry no count byte; any length until host ends it.
// (RULE15) Device answers the alert response address, loosely.
// (RULE16) Write byte: address, register, one data byte, each acknowledged.
// (RULE17) Block write advances pointer per byte, wrapping FFh to 00h.
// (RULE18) Read byte: register phase, repeated start, read, data, host nack.
// (RULE19) Block read advances pointer per byte until host nack.
// (RULE20) All bus traffic ignored for 15ms after power-up.
// (RULE21) SPI chip select ignored when a non-SPI protocol is strapped.
// (RULE22) Companion link carries only single-byte register reads and writes.
// (RULE23) Send byte only loads the register pointer.
// (RULE24) Receive byte returns the register at the current pointer.
// (RULE25) Clock and data are synchronised and filtered before detection.
// (RULE26) Foreign address: data line stays released until the transaction ends.
`timescale 1ns/1ps
`default_nettype none
module shbsi_slave #(
  parameter int POWERUP_CYC = shbsi_pkg::POWERUP_CYC,
  parameter int TIMEOUT_CYC = shbsi_pkg::TIMEOUT_CYC,
  parameter int IDLE_CYC    = shbsi_pkg::IDLE_CYC
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RESET_N,
  input  wire logic [2:0] PROTOCOL_SELECT_STRAP,
  input  wire logic       SPI_CS_N,
  input  wire logic       TIMEOUT_EN,
  input  wire logic       BUS_CLOCK_PIN_I,
  output logic            BUS_CLOCK_PIN_O,
  output logic            BUS_CLOCK_PIN_OE_N,
  input  wire logic       BUS_DATA_PIN_I,
  output logic            BUS_DATA_PIN_O,
  output logic            BUS_DATA_PIN_OE_N,
  output logic [2:0]      PROTOCOL_MODE,
  output logic            BUS_READY,
  output logic [7:0]      REG_ADDR,
  output logic [7:0]      REG_WDATA,
  output logic            REG_WE,
  output logic            REG_RE,
  input  wire logic [7:0] REG_RDATA
);
  localparam int CW = shbsi_pkg::CNT_W;

  shbsi_line_if line ();

  shbsi_pkg::shbsi_state_t state_q;
  shbsi_pkg::shbsi_strap_t strap_q;
  logic [2:0]    strap_s1_q;
  logic [2:0]    strap_s2_q;
  logic [CW-1:0] pwr_cnt_q;
  logic          pwr_done_q;
  logic [CW-1:0] idle_cnt_q;
  logic [CW-1:0] tmo_cnt_q;
  logic          idle_hit;
  logic          tmo_hit;
  logic          smbus_mode;
  logic          active;
  logic [6:0]    slave_addr;
  logic [3:0]    bitcnt_q;
  logic [7:0]    rx_q;
  logic [7:0]    tx_q;
  logic [7:0]    ptr_q;
  logic [7:0]    wdata_q;
  logic          drive_q;
  logic          rnw_q;
  logic          alert_q;
  logic          we_q;
  logic          re_q;
  logic          addr_hit;
  logic          alert_hit;

  // RULE25
  shbsi_line_filter u_filter (
    .clk     (CLK_SYS),
    .rst_n   (RESET_N),
    .scl_pin (BUS_CLOCK_PIN_I),
    .sda_pin (BUS_DATA_PIN_I),
    .line    (line.filt)
  );

  // Strap is static but still crosses in through two flops
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
    end else begin
      strap_s1_q <= PROTOCOL_SELECT_STRAP;
      strap_s2_q <= strap_s1_q;
    end
  end

  // Tracked during the hold-off, frozen once the bus wakes up
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_q <= shbsi_pkg::SHBSI_SPI4;
    end else if (!pwr_done_q) begin
      strap_q <= shbsi_pkg::shbsi_strap_t'(strap_s2_q); // RULE1
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      pwr_cnt_q  <= '0;
      pwr_done_q <= 1'b0;
    end else if (!pwr_done_q) begin
      pwr_cnt_q  <= pwr_cnt_q + CW'(1);
      pwr_done_q <= (pwr_cnt_q == CW'(POWERUP_CYC - 1)); // RULE20
    end
  end

  always_comb begin
    unique case (strap_q)
      shbsi_pkg::SHBSI_R82K:    slave_addr = shbsi_pkg::ADDR_R82K; // RULE2
      shbsi_pkg::SHBSI_R100K:   slave_addr = shbsi_pkg::ADDR_R100K;
      shbsi_pkg::SHBSI_R120K:   slave_addr = shbsi_pkg::ADDR_R120K;
      shbsi_pkg::SHBSI_R150K:   slave_addr = shbsi_pkg::ADDR_R150K;
      default:                  slave_addr = shbsi_pkg::ADDR_TIED_HI;
    endcase
  end

  // SPI and companion-link classes leave this slave and SPI_CS_N unused
  assign smbus_mode = (strap_q >= shbsi_pkg::SHBSI_R82K); // RULE21 RULE22
  assign active     = smbus_mode & pwr_done_q; // RULE20
  assign addr_hit   = (rx_q[7:1] == slave_addr); // RULE6
  assign alert_hit  = (rx_q[7:1] == shbsi_pkg::ADDR_ALERT) & rx_q[0]; // RULE15

  // Bus idle: both lines high, counted in system clocks
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      idle_cnt_q <= '0;
    end else if (!(line.scl & line.sda) || idle_hit) begin
      idle_cnt_q <= '0;
    end else begin
      idle_cnt_q <= idle_cnt_q + CW'(1);
    end
  end
  assign idle_hit = (idle_cnt_q == CW'(IDLE_CYC)); // RULE13

  // Any clock edge counts as activity; held clock low counts toward timeout
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      tmo_cnt_q <= '0;
    end else if (!TIMEOUT_EN || line.scl || tmo_hit) begin
      tmo_cnt_q <= '0; // RULE12
    end else begin
      tmo_cnt_q <= tmo_cnt_q + CW'(1);
    end
  end
  assign tmo_hit = (tmo_cnt_q == CW'(TIMEOUT_CYC)); // RULE11

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q  <= shbsi_pkg::ST_IDLE;
      bitcnt_q <= 4'h0;
      rx_q     <= 8'h00;
      tx_q     <= 8'h00;
      ptr_q    <= 8'h00;
      wdata_q  <= 8'h00;
      drive_q  <= 1'b0;
      rnw_q    <= 1'b0;
      alert_q  <= 1'b0;
      we_q     <= 1'b0;
      re_q     <= 1'b0;
    end else begin
      we_q <= 1'b0;
      re_q <= 1'b0;
      if (!active || line.stop || idle_hit || tmo_hit) begin
        state_q <= shbsi_pkg::ST_IDLE; // RULE10 RULE11 RULE13
        drive_q <= 1'b0;
      end else if (line.start) begin
        state_q  <= shbsi_pkg::ST_ADDR; // RULE5
        bitcnt_q <= 4'h0;
        drive_q  <= 1'b0;
      end else begin
        unique case (state_q) // RULE3
          shbsi_pkg::ST_IDLE, shbsi_pkg::ST_IGNORE: begin
            drive_q <= 1'b0; // RULE26
          end
          shbsi_pkg::ST_ADDR, shbsi_pkg::ST_REG, shbsi_pkg::ST_WDATA: begin
            if (line.scl_rise) begin
              rx_q     <= {rx_q[6:0], line.sda}; // RULE7
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (line.scl_fall &&
                         bitcnt_q == shbsi_pkg::BITS_PER_BYTE) begin
              bitcnt_q <= 4'h0;
              if (state_q == shbsi_pkg::ST_ADDR) begin
                if (addr_hit || alert_hit) begin
                  drive_q <= 1'b1; // RULE8
                  rnw_q   <= rx_q[0];
                  alert_q <= alert_hit;
                  state_q <= shbsi_pkg::ST_ADDR_ACK;
                end else begin
                  state_q <= shbsi_pkg::ST_IGNORE; // RULE26
                end
              end else if (state_q == shbsi_pkg::ST_REG) begin
                ptr_q   <= rx_q; // RULE23
                drive_q <= 1'b1; // RULE8
                state_q <= shbsi_pkg::ST_REG_ACK;
              end else begin
                wdata_q <= rx_q;
                we_q    <= 1'b1; // RULE16
                drive_q <= 1'b1; // RULE8
                state_q <= shbsi_pkg::ST_WDATA_ACK;
              end
            end
          end
          shbsi_pkg::ST_ADDR_ACK, shbsi_pkg::ST_REG_ACK,
          shbsi_pkg::ST_WDATA_ACK: begin
            if (line.scl_fall) begin
              if (state_q == shbsi_pkg::ST_ADDR_ACK && rnw_q) begin
                // Alert answer is just our own address, not arbitrated
                tx_q     <= alert_q ? {slave_addr, 1'b0} : REG_RDATA; // RULE15 RULE24
                drive_q  <= alert_q ? ~slave_addr[6] : ~REG_RDATA[7];
                re_q     <= ~alert_q;
                bitcnt_q <= 4'h1;
                state_q  <= shbsi_pkg::ST_RDATA; // RULE18
              end else begin
                drive_q <= 1'b0;
                if (state_q == shbsi_pkg::ST_WDATA_ACK) begin
                  ptr_q <= ptr_q + 8'h01; // RULE17
                end
                // No count byte: every further byte is data
                state_q <= (state_q == shbsi_pkg::ST_ADDR_ACK) ?
                           shbsi_pkg::ST_REG : shbsi_pkg::ST_WDATA; // RULE14
              end
            end
          end
          shbsi_pkg::ST_RDATA: begin
            if (line.scl_fall) begin
              if (bitcnt_q == shbsi_pkg::BITS_PER_BYTE) begin
                drive_q  <= 1'b0;
                bitcnt_q <= 4'h0;
                state_q  <= shbsi_pkg::ST_RACK;
              end else begin
                tx_q     <= {tx_q[6:0], 1'b0};
                drive_q  <= ~tx_q[6]; // RULE7
                bitcnt_q <= bitcnt_q + 4'h1;
              end
            end
          end
          shbsi_pkg::ST_RACK: begin
            if (line.scl_rise) begin
              if (!line.sda && !alert_q) begin
                ptr_q   <= ptr_q + 8'h01; // RULE19
                state_q <= shbsi_pkg::ST_RNEXT;
              end else begin
                state_q <= shbsi_pkg::ST_IGNORE; // RULE9
              end
            end
          end
          shbsi_pkg::ST_RNEXT: begin
            if (line.scl_fall) begin
              tx_q     <= REG_RDATA; // RULE19
              drive_q  <= ~REG_RDATA[7];
              re_q     <= 1'b1;
              bitcnt_q <= 4'h1;
              state_q  <= shbsi_pkg::ST_RDATA;
            end
          end
          default: begin
            state_q <= shbsi_pkg::ST_IDLE;
            drive_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open drain: only ever pull low; clock pin is never driven
  assign BUS_DATA_PIN_O     = 1'b0;
  assign BUS_DATA_PIN_OE_N  = ~drive_q;
  assign BUS_CLOCK_PIN_O    = 1'b0;
  assign BUS_CLOCK_PIN_OE_N = 1'b1; // RULE4
  assign PROTOCOL_MODE      = strap_q;
  assign BUS_READY          = pwr_done_q;
  assign REG_ADDR           = ptr_q;
  assign REG_WDATA          = wdata_q;
  assign REG_WE             = we_q;
  assign REG_RE             = re_q;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  a_clock_never_held: // RULE4
    assert property (BUS_CLOCK_PIN_OE_N && $stable(BUS_CLOCK_PIN_OE_N))
    else $error("clock line driven by slave");

  a_holdoff_silent: // RULE20
    assert property (!pwr_done_q |-> BUS_DATA_PIN_OE_N && !REG_WE)
    else $error("bus answered during power-up hold-off");

  a_start_to_addr: // RULE5
    assert property (active && line.start && !line.stop && !idle_hit
                     && !tmo_hit |=> state_q == shbsi_pkg::ST_ADDR
                     && BUS_DATA_PIN_OE_N)
    else $error("start not followed by address phase");

  a_stop_clears: // RULE10
    assert property (line.stop |=> state_q == shbsi_pkg::ST_IDLE
                     && BUS_DATA_PIN_OE_N)
    else $error("stop did not reset the slave");

  a_ack_on_match: // RULE8
    assert property (state_q == shbsi_pkg::ST_ADDR && active
                     && line.scl_fall && bitcnt_q == 4'h8 && addr_hit
                     && !line.start && !line.stop && !idle_hit && !tmo_hit
                     |=> !BUS_DATA_PIN_OE_N [*1] ##0
                     state_q == shbsi_pkg::ST_ADDR_ACK)
    else $error("matching address not acknowledged");

  a_foreign_quiet: // RULE26
    assert property (state_q == shbsi_pkg::ST_IGNORE && !line.start
                     |=> BUS_DATA_PIN_OE_N)
    else $error("data driven for a foreign address");

  a_write_advances: // RULE17
    assert property (state_q == shbsi_pkg::ST_WDATA_ACK && line.scl_fall
                     && active && !line.stop && !line.start
                     && !idle_hit && !tmo_hit
                     |=> REG_ADDR == $past(REG_ADDR) + 8'h01)
    else $error("pointer not advanced after write byte");

  a_write_strobe: // RULE16
    assert property ($rose(REG_WE) |=> !REG_WE
                     && state_q == shbsi_pkg::ST_WDATA_ACK
                     && !BUS_DATA_PIN_OE_N)
    else $error("write strobe without acknowledge");

  a_msb_first: // RULE7
    assert property (state_q == shbsi_pkg::ST_RDATA && bitcnt_q == 4'h1
                     && !alert_q |-> BUS_DATA_PIN_OE_N == tx_q[7])
    else $error("read byte not sent msb first");

  a_timeout_off: // RULE12
    assert property (!TIMEOUT_EN |=> tmo_cnt_q == '0 && !tmo_hit)
    else $error("timeout counting while disabled");

  a_idle_reset: // RULE13
    assert property (idle_hit |=> state_q == shbsi_pkg::ST_IDLE)
    else $error("bus idle did not reset slave");

  a_mode_gate: // RULE21
    assert property (!smbus_mode |-> BUS_DATA_PIN_OE_N
                     && state_q == shbsi_pkg::ST_IDLE)
    else $error("slave active in a non-bus protocol");

  c_write_byte:
    cover property ($rose(REG_WE));
  c_block_read:
    cover property (state_q == shbsi_pkg::ST_RNEXT ##[1:1000]
                    state_q == shbsi_pkg::ST_RDATA);
  c_foreign:
    cover property (state_q == shbsi_pkg::ST_IGNORE);
  c_timeout:
    cover property (tmo_hit);
endmodule
`default_nettype wire

// ### test/shbsi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module shbsi_host_model (
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // Start: both lines released, then data pulled low while clock is high, then clock pulled low
  task automatic start_cond();
    #50 sda_low = 1'b0;
    #150 scl_low = 1'b0;
    #100 sda_low = 1'b1;
    #100 scl_low = 1'b1;
  endtask

  task automatic stop_cond();
    #50 sda_low = 1'b1;
    #50 scl_low = 1'b0;
    #100 sda_low = 1'b0;
    #100;
  endtask

  // Low phase outlasts the slave's pin filter, so a bit it drives after
  // the clock falls has settled before the clock rises again
  task automatic put_bit(input logic b, output logic r);
    #50 sda_low = ~b;
    #100 scl_low = 1'b0;
    #90 r = sda;
    #10 scl_low = 1'b1;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    #100;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], r);
    end
    put_bit(1'b1, ack);
  endtask

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, d[i]);
    end
    #100;
    put_bit(last, r);
  endtask

  // Clock is raised with data high and left there for ns
  task automatic hold_high(input int ns);
    #50 sda_low = 1'b0;
    #150 scl_low = 1'b0;
    #(ns) scl_low = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### test/shbsi_slave_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module shbsi_slave_tb_top;
  localparam int PWR = 50;
  localparam int TMO = 400;
  localparam int IDL = 300;
  logic       clk_sys    = 1'b0;
  logic       reset_n    = 1'b0;
  logic [2:0] strap      = 3'h3;
  logic       spi_cs_n   = 1'b1;
  logic       timeout_en = 1'b0;
  logic       scl_low;
  logic       sda_low;
  logic       clk_o;
  logic       clk_oe_n;
  logic       dat_o;
  logic       dat_oe_n;
  logic       bus_ready;
  logic       reg_we;
  logic       reg_re;
  logic [2:0] mode;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] regs [256];
  int         fail_count = 0;
  int         compares   = 0;
  int         we_cnt     = 0;
  int         re_cnt     = 0;
  wire        scl_w = ~(scl_low | (~clk_oe_n & ~clk_o));
  wire        sda_w = ~(sda_low | (~dat_oe_n & ~dat_o));

  shbsi_slave #(.POWERUP_CYC(PWR), .TIMEOUT_CYC(TMO), .IDLE_CYC(IDL))
  u_shbsi_slave (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .PROTOCOL_SELECT_STRAP(strap),
    .SPI_CS_N(spi_cs_n), .TIMEOUT_EN(timeout_en),
    .BUS_CLOCK_PIN_I(scl_w), .BUS_CLOCK_PIN_O(clk_o),
    .BUS_CLOCK_PIN_OE_N(clk_oe_n), .BUS_DATA_PIN_I(sda_w),
    .BUS_DATA_PIN_O(dat_o), .BUS_DATA_PIN_OE_N(dat_oe_n),
    .PROTOCOL_MODE(mode), .BUS_READY(bus_ready), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RE(reg_re),
    .REG_RDATA(regs[reg_addr])
  );
  shbsi_host_model u_shbsi_host_model (
    .sda(sda_w), .scl_low(scl_low), .sda_low(sda_low)
  );

  initial begin
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'(i) ^ 8'h3C;
    end
  end
  always @(posedge clk_sys) begin
    if (reg_we) begin
      regs[reg_addr] <= reg_wdata;
      we_cnt <= we_cnt + 1;
    end
    if (reg_re) begin
      re_cnt <= re_cnt + 1;
    end
    if (reset_n && (clk_oe_n !== 1'b1 || clk_o !== 1'b0)) begin
      check({6'h00, clk_o, clk_oe_n}, 8'h01);
    end
  end
  initial forever #12.5 clk_sys = ~clk_sys;
  // Chip select wanders throughout; the slave must not care
  initial forever begin
    repeat (7) @(posedge clk_sys);
    #2 spi_cs_n = ~spi_cs_n;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic go();
    u_shbsi_host_model.start_cond();
  endtask
  task automatic sp();
    u_shbsi_host_model.stop_cond();
  endtask
  task automatic wb(input logic [7:0] d, output logic a);
    u_shbsi_host_model.wbyte(d, a);
  endtask
  task automatic rb(input logic last, output logic [7:0] d);
    u_shbsi_host_model.rbyte(last, d);
  endtask

  task automatic do_reset(input logic [2:0] s);
    @(posedge clk_sys);
    #2 reset_n = 1'b0;
    strap = s;
    repeat (16) @(posedge clk_sys);
    #2 reset_n = 1'b1;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (bus_ready !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #2;
      n++;
    end
    check(8'(bus_ready), 8'h01);
  endtask

  task automatic t_powerup();
    logic a;
    do_reset(3'h3);
    check(8'(bus_ready), 8'h00);
    go();
    wb(8'h58, a);
    sp();
    check(8'(a), 8'h01);
    wait_ready();
    $display("test powerup done");
  endtask

  task automatic t_strap();
    logic       a;
    logic [7:0] d;
    logic [6:0] own;
    for (int s = 0; s < 8; s++) begin
      do_reset(3'(s));
      wait_ready();
      check(8'(mode), 8'(s));
      own = (s < 3) ? 7'h2C : 7'h2F - 7'(s);
      go();
      wb({own, 1'b0}, a);
      sp();
      check(8'(a), (s < 3) ? 8'h01 : 8'h00);
      if (s >= 3) begin
        go();
        wb({7'h0C, 1'b1}, a);
        rb(1'b1, d);
        sp();
        check(8'(a), 8'h00);
        check(d, {own, 1'b0});
      end
    end
    do_reset(3'h3);
    wait_ready();
    $display("test strap done");
  endtask

  task automatic t_write();
    logic [4:0] a;
    logic [7:0] seq [5];
    int         we0;
    seq = '{8'h58, 8'hFE, 8'hA5, 8'h5A, 8'h3C};
    we0 = we_cnt;
    go();
    for (int i = 0; i < 5; i++) begin
      wb(seq[i], a[i]);
    end
    sp();
    check(8'(a), 8'h00);
    check(regs[8'hFE], 8'hA5);
    check(regs[8'hFF], 8'h5A);
    check(regs[8'h00], 8'h3C);
    check(8'(we_cnt - we0), 8'h03);
    $display("test write done");
  endtask

  task automatic t_read();
    logic [2:0] a;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] d2;
    int         re0;
    re0 = re_cnt;
    go();
    wb(8'h58, a[0]);
    wb(8'hFF, a[1]);
    go();
    wb(8'h59, a[2]);
    rb(1'b0, d0);
    rb(1'b0, d1);
    rb(1'b1, d2);
    sp();
    check(8'(a), 8'h00);
    check(d0, 8'h5A);
    check(d1, 8'h3C);
    check(d2, 8'h3D);
    check(reg_addr, 8'h01);
    check(8'(re_cnt - re0), 8'h03);
    $display("test read done");
  endtask

  task automatic t_sendrecv();
    logic       a;
    logic [7:0] d;
    int         we0;
    we0 = we_cnt;
    go();
    wb(8'h58, a);
    wb(8'h10, a);
    sp();
    check(reg_addr, 8'h10);
    check(8'(we_cnt - we0), 8'h00);
    for (int k = 0; k < 2; k++) begin
      go();
      wb(8'h59, a);
      rb(1'b1, d);
      sp();
      check(8'(a), 8'h00);
      check(d, 8'h2C);
    end
    check(reg_addr, 8'h10);
    $display("test send receive done");
  endtask

  task automatic t_foreign();
    logic a;
    go();
    wb(8'h5A, a);
    check(8'(a), 8'h01);
    wb(8'h20, a);
    sp();
    check(8'(a), 8'h01);
    go();
    wb(8'h58, a);
    sp();
    u_shbsi_host_model.hold_high(100);
    wb(8'h58, a);
    sp();
    check(8'(a), 8'h01);
    check(reg_addr, 8'h10);
    $display("test foreign done");
  endtask

  task automatic t_timeout();
    logic a;
    for (int en = 0; en < 2; en++) begin
      @(posedge clk_sys);
      #2 timeout_en = 1'(en);
      go();
      wb(8'h58, a);
      #(TMO * 25 + 2500);
      wb(8'h30 + 8'(en), a);
      sp();
      check(8'(a), 8'(en));
      check(reg_addr, 8'h30);
    end
    $display("test timeout done");
  endtask

  task automatic t_idle();
    logic a;
    logic r;
    go();
    wb(8'h58, a);
    u_shbsi_host_model.hold_high(IDL * 25 + 2500);
    for (int i = 0; i < 7; i++) begin
      u_shbsi_host_model.put_bit(1'b0, r);
    end
    u_shbsi_host_model.put_bit(1'b1, a);
    sp();
    check(8'(a), 8'h01);
    check(reg_addr, 8'h30);
    $display("test idle done");
  endtask

  initial begin
    t_powerup();
    t_strap();
    t_write();
    t_read();
    t_sendrecv();
    t_foreign();
    t_timeout();
    t_idle();
    summarize();
  end
  // Whole run needs well under half of this span
  initial begin
    #2000000;
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
